// [pkg/host_port_pkg.sv]
// Operation
// - Write: select high command, low data/parameter
// - Read: select high data/cursor, low status
// - Separate strobes: capture data on write rising
// - Separate strobes: drive data while read low
// - Enable mode: drive while high, capture falling
// - Access accepted only while chip select low
// - Reset low resets; release high to run
// - Strap high enable-strobe, low separate-strobe
// - Default strap low selects separate strobes
`default_nettype none
package host_port_pkg;
	// ****************************************
	// Constants
	// ****************************************
	localparam int DATA_W = 8;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic STRAP_DEFAULT = 1'b0;
	localparam logic SEL_CMD = 1'b1;
	localparam logic DIR_READ = 1'b1;
	typedef enum logic {STYLE_SEPARATE, STYLE_ENABLE} bus_style_t;
endpackage
`default_nettype wire

// [design/edge_catch.sv]
`default_nettype none
module edge_catch
	import host_port_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic level_i,
	output logic rise_o,
	output logic fall_o
);
	typedef struct packed {
		logic prev;
	} edge_state_t;
	edge_state_t state_q, state_d;

	// Previous level, idle high
	always_comb begin
		state_d = state_q;
		state_d.prev = level_i;
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= '{prev: 1'b1};
		end else if (clk_en_i) begin
			state_q <= state_d;
		end
	end

	assign rise_o = clk_en_i & level_i & ~state_q.prev;
	assign fall_o = clk_en_i & ~level_i & state_q.prev;
endmodule
`default_nettype wire

// [design/lcd_module_host_bus_port.sv]
`default_nettype none
module lcd_module_host_bus_port
	import host_port_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic reset_n_i,
	input wire logic chip_select_n_i,
	input wire logic register_select_i,
	input wire logic write_n_dir_i,
	input wire logic read_n_enable_i,
	input wire logic interface_style_strap_i,
	input wire logic [DATA_W-1:0] host_data_bus_i,
	output logic [DATA_W-1:0] host_data_bus_o,
	output logic host_data_bus_oe_o,
	input wire logic [DATA_W-1:0] status_i,
	input wire logic [DATA_W-1:0] read_data_i,
	output logic wr_valid_o,
	output logic wr_is_command_o,
	output logic [DATA_W-1:0] wr_data_o,
	output logic rd_data_taken_o,
	output logic style_enable_o,
	output logic core_reset_o
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		bus_style_t style;
		logic started;
		logic wr_valid;
		logic wr_cmd;
		logic [DATA_W-1:0] wr_data;
		logic [DATA_W-1:0] rd_data;
		logic rd_sel;
		logic rd_active;
		logic rd_done;
	} port_state_t;
	port_state_t state_q, state_d;

	logic wr_rise, unused_wr_fall, en_rise_unused, en_fall;
	logic style_en, sel, rd_req, wr_edge, in_reset;

	// One catcher per strobe pin
	edge_catch u_wr_edge (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.level_i(write_n_dir_i),
		.rise_o(wr_rise),
		.fall_o(unused_wr_fall)
	);
	edge_catch u_en_edge (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.level_i(read_n_enable_i),
		.rise_o(en_rise_unused),
		.fall_o(en_fall)
	);

	// ****************************************
	// Access decode
	// ****************************************
	assign in_reset = ~reset_n_i;
	assign style_en = (state_q.style == STYLE_ENABLE);
	// Blocked until the strap is taken: the edge catchers reset to an idle-high
	// level, so a low enable pin would look like a falling edge on the first cycle
	assign sel = ~chip_select_n_i & ~in_reset & state_q.started;
	// Read request per style
	assign rd_req = sel & (style_en ? (read_n_enable_i & (write_n_dir_i == DIR_READ))
		: ~read_n_enable_i);
	// Write edge: rising write strobe, or falling enable with direction low
	assign wr_edge = sel & (style_en ? (en_fall & (write_n_dir_i != DIR_READ))
		: wr_rise);

	// Next-state logic
	always_comb begin
		state_d = state_q;
		state_d.wr_valid = 1'b0;
		state_d.rd_done = 1'b0;
		// Strap caught once after reset release; strap is static in use
		if (!state_q.started) begin
			state_d.started = 1'b1;
			state_d.style = interface_style_strap_i ? STYLE_ENABLE : STYLE_SEPARATE;
		end
		if (in_reset) begin
			state_d.rd_active = 1'b0;
			state_d.wr_data = BYTE_RESET;
			state_d.wr_cmd = 1'b0;
		end else begin
			if (wr_edge) begin
				state_d.wr_valid = 1'b1;
				state_d.wr_data = host_data_bus_i;
				state_d.wr_cmd = (register_select_i == SEL_CMD);
			end
			// Read value held stable for the whole strobe
			if (rd_req && !state_q.rd_active) begin
				state_d.rd_sel = register_select_i;
				state_d.rd_data = (register_select_i == SEL_CMD) ? read_data_i : status_i;
			end
			if (!rd_req && state_q.rd_active) begin
				state_d.rd_done = state_q.rd_sel; // Data read advances
			end
			state_d.rd_active = rd_req;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= '{style: STYLE_SEPARATE, started: 1'b0, wr_valid: 1'b0, wr_cmd: 1'b0,
				wr_data: BYTE_RESET, rd_data: BYTE_RESET, rd_sel: 1'b0, rd_active: 1'b0,
				rd_done: 1'b0};
		end else if (clk_en_i) begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign host_data_bus_o = state_q.rd_data;
	assign host_data_bus_oe_o = state_q.rd_active & rd_req;
	assign wr_valid_o = state_q.wr_valid;
	assign wr_is_command_o = state_q.wr_cmd;
	assign wr_data_o = state_q.wr_data;
	assign rd_data_taken_o = state_q.rd_done;
	assign style_enable_o = style_en;
	assign core_reset_o = in_reset | reset_i;
endmodule
`default_nettype wire

// [tb/host_port_checker.sv]
`default_nettype none
// ****
// Port checker
// ****
module host_port_checker (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic reset_n_i,
	input wire logic chip_select_n_i,
	input wire logic register_select_i,
	input wire logic write_n_dir_i,
	input wire logic read_n_enable_i,
	input wire logic host_data_bus_oe_o,
	input wire logic wr_valid_o,
	input wire logic wr_is_command_o,
	input wire logic style_enable_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// Write pulse split by style
	sequence wr_sep; wr_valid_o && !style_enable_o; endsequence
	sequence wr_en; wr_valid_o && style_enable_o; endsequence
	a_oe_select: assert property (host_data_bus_oe_o |-> !chip_select_n_i && reset_n_i) else $error("oe");
	a_oe_strobe: assert property (host_data_bus_oe_o && !style_enable_o |-> !read_n_enable_i) else $error("oe");
	a_oe_enable: assert property (host_data_bus_oe_o && style_enable_o |-> read_n_enable_i && write_n_dir_i) else $error("oe");
	a_wr_rise: assert property (wr_sep |-> $past(write_n_dir_i)) else $error("wr");
	a_wr_fall: assert property (wr_en |-> !$past(read_n_enable_i) && !$past(write_n_dir_i)) else $error("wr");
	a_wr_pulse: assert property (wr_valid_o |=> !wr_valid_o) else $error("wr");
	a_wr_kind: assert property (wr_valid_o |-> wr_is_command_o == $past(register_select_i)) else $error("cmd");
	a_cs_idle: assert property (chip_select_n_i [*3] |=> !wr_valid_o) else $error("cs");
	a_rst_block: assert property (!reset_n_i [*2] |=> !wr_valid_o) else $error("rst");
endmodule
bind lcd_module_host_bus_port host_port_checker checker_inst (.*);
`default_nettype wire

// [tb/host_model.sv]
`default_nettype none
// ****
// Host side
// ****
module host_model (
	input wire logic clk_i,
	input wire logic style_i,
	input wire logic oe_i,
	input wire logic [7:0] dev_i,
	output logic cs_n_o = 1'b1,
	output logic rs_o = 1'b0,
	output logic wn_o = 1'b1,
	output logic rn_o = 1'b1,
	output logic [7:0] bus_o
);
	logic [7:0] drv = 8'h00;
	// Released bus shows the inverse, never a stale byte
	assign bus_o = oe_i ? dev_i : drv;
	// One access, strobes held three cycles
	task acc(input logic r, s, c, input logic [7:0] v, output logic [7:0] got);
		// Idle strobe levels settle while still deselected, then select
		@(posedge clk_i) #1;
		rs_o = s;
		drv = v;
		wn_o = style_i ? r : 1'b1;
		rn_o = !style_i;
		@(posedge clk_i) #1;
		cs_n_o = c;
		@(posedge clk_i);
		#1 if (style_i) rn_o = 1'b1; else if (r) rn_o = 1'b0; else wn_o = 1'b0;
		repeat (3) @(posedge clk_i);
		got = oe_i ? dev_i : 8'hXX;
		#1 wn_o = style_i ? r : 1'b1;
		rn_o = !style_i;
		repeat (2) @(posedge clk_i);
		#1 cs_n_o = 1'b1;
		drv = ~v;
	endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import host_port_pkg::*;
	logic ref_clk_i = 0, reset_i = 1, rst_n = 1, strap = 0, cs_n, rs, wn, rn, oe, wv, wc, se, cr, tk;
	logic [7:0] st = 8'h5A, rd = 8'hC3, bus, q, wd, g;
	int err_count = 0, checked = 0, pulses = 0, p, taken = 0, tp;
	always #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) pulses += (wv === 1'b1);
	always @(posedge ref_clk_i) taken += (tk === 1'b1);
	host_model host_model_inst (.clk_i(ref_clk_i), .style_i(strap), .oe_i(oe), .dev_i(q), .cs_n_o(cs_n),
		.rs_o(rs), .wn_o(wn), .rn_o(rn), .bus_o(bus));
	lcd_module_host_bus_port lcd_module_host_bus_port_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.clk_en_i(1'b1), .reset_n_i(rst_n), .chip_select_n_i(cs_n), .register_select_i(rs), .write_n_dir_i(wn),
		.read_n_enable_i(rn), .interface_style_strap_i(strap), .host_data_bus_i(bus), .host_data_bus_o(q),
		.host_data_bus_oe_o(oe), .status_i(st), .read_data_i(rd), .wr_valid_o(wv), .wr_is_command_o(wc),
		.wr_data_o(wd), .rd_data_taken_o(tk), .style_enable_o(se), .core_reset_o(cr));
	task chk(input string n, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task results;
		if (err_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Strap taken after reset release
	task t_mode(input logic s);
		#1 reset_i = 1;
		strap = s;
		repeat (8) @(posedge ref_clk_i);
		#1 reset_i = 0;
		repeat (3) @(posedge ref_clk_i);
		chk("style", {7'h00, se}, {7'h00, s});
	endtask
	task t_write(input logic s, input logic [7:0] v);
		p = pulses;
		host_model_inst.acc(1'b0, s, 1'b0, v, g);
		chk("pulses", 8'(pulses - p), 8'h01);
		chk("cmd", {7'h00, wc}, {7'h00, s});
		chk("wdata", wd, v);
	endtask
	task t_read(input logic s);
		tp = taken;
		host_model_inst.acc(1'b1, s, 1'b0, 8'h00, g);
		chk("rdata", g, s ? rd : st);
		chk("taken", 8'(taken - tp), {7'h00, s});
	endtask
	// Deselected or held in reset: nothing happens
	task t_blocked(input logic c, r);
		#1 rst_n = r;
		p = pulses;
		tp = taken;
		host_model_inst.acc(1'b0, 1'b1, c, 8'h77, g);
		host_model_inst.acc(1'b1, 1'b1, c, 8'h00, g);
		chk("idle", 8'(pulses - p), 8'h00);
		chk("float", g, 8'hXX);
		chk("core_rst", {7'h00, cr}, {7'h00, !r});
		chk("no_take", 8'(taken - tp), 8'h00);
		if (!r) chk("wclear", wd, BYTE_RESET);
		#1 rst_n = 1;
	endtask
	initial begin
		for (int m = 0; m < 2; m++) begin
			t_mode(m[0]);
			t_write(1'b1, 8'hA5);
			t_write(1'b0, 8'h3C);
			t_read(1'b0);
			t_read(1'b1);
			t_blocked(1'b1, 1'b1);
			t_blocked(1'b0, 1'b0);
		end
		results();
	end
endmodule
`default_nettype wire
